// ==== verilog/gpf_regs.svh ====
// Register offsets, field positions, reset values and masks of the pin control block
`ifndef GPF_REGS_SVH
`define GPF_REGS_SVH

// Register indices; the byte address is four times the index
`define GPF_IDX_CONFIG      8'h06
`define GPF_IDX_IDENT       8'h07
`define GPF_IDX_IRQ_STAT    8'h20
`define GPF_IDX_IRQ_MASK    8'h21

// Field positions in general_pin_config
`define GPF_FAULT_MODE_HI   10
`define GPF_FAULT_MODE_LO   9
`define GPF_FAULT_LEVEL     8
`define GPF_RSVD_HI         7
`define GPF_RSVD_LO         6
`define GPF_P1_IN_EN        5
`define GPF_P0_IN_EN        4
`define GPF_P1_OUT_EN       3
`define GPF_P0_OUT_EN       2
`define GPF_P1_LEVEL        1
`define GPF_P0_LEVEL        0

// Writable bits of general_pin_config; all others read as zero
`define GPF_CONFIG_WMASK    16'h073f
`define GPF_CONFIG_RST      16'h0000

// Interrupt status and mask layout
`define GPF_IRQ_W           3
`define GPF_IRQ_FAULT       0
`define GPF_IRQ_PIN0        1
`define GPF_IRQ_PIN1        2
`define GPF_IRQ_MASK_RST    3'h0

`endif

// ==== verilog/gpf_pkg.sv ====
// Types shared by the pin control block
package gpf_pkg;

    typedef enum logic [1:0] {
        FM_OFF   = 2'b00,
        FM_ERRIN = 2'b01,
        FM_ODERR = 2'b10,
        FM_GPO   = 2'b11
    } gpf_fault_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } gpf_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gpf_wb_rsp_t;

    typedef struct packed {
        logic out;
        logic oeN;
    } gpf_pin_drv_t;

endpackage

// ==== verilog/gpf_pin_cell.sv ====
// Registered driver for one pin: level and active-low output enable
`timescale 1ns/100ps
module gpf_pin_cell (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             drive,
    input  wire logic             level,
    output gpf_pkg::gpf_pin_drv_t pin
);
    import gpf_pkg::*;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin.out <= 1'b0;
            pin.oeN <= 1'b1;
        end else if (ce) begin
            pin.out <= level;
            pin.oeN <= ~drive;
        end
    end

endmodule

// ==== verilog/gpf_pin_control.sv ====
// General pin and fault pin control with its register file on a Wishbone slave
//
// Summary of operation
// - A two-bit fault pin function field sits at bits 10:9 and the value 00 leaves the pin without function.
// - Function 01 makes the fault pin an input whose inverted level joins the other errors in the fault flag.
// - Function 10 makes the fault pin open-drain, pulled low whenever any error bit is set.
// - Function 11 drives the fault pin actively to the fault pin level bit.
// - Bit 8 sets the driven fault pin level and reads back the pin when it is an input; it resets to 0.
// - Bits 5 and 4 make general pin 1 and 0 inputs; both reset to 0.
// - Bits 3 and 2 make general pin 1 and 0 outputs; both reset to 0.
// - Bits 1 and 0 are the written output level or the read input state of general pin 1 and 0.
// - Bits 7:6 are reserved, read as zero, and software writes zero to them.
// - The identity register at index 0x07 returns a fixed 16-bit code and ignores writes.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "gpf_regs.svh"

module gpf_pin_control #(
    parameter int          ERR_W   = 4,
    // Arbitrary identity value
    parameter logic [15:0] ID_CODE = 16'h5a3c
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire gpf_pkg::gpf_wb_req_t   wbReq,
    output gpf_pkg::gpf_wb_rsp_t        wbRsp,
    input  wire logic [ERR_W-1:0]       errSources,
    output logic                        adcFault,
    input  wire logic                   faultPinIn,
    output gpf_pkg::gpf_pin_drv_t       faultPin,
    input  wire logic [1:0]             gpIn,
    output gpf_pkg::gpf_pin_drv_t [1:0] gpPin,
    output logic                        irq
);
    import gpf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Word index from a byte address
    function automatic logic [7:0] wordIndex(input logic [11:0] adr);
        wordIndex = adr[9:2];
    endfunction

    // Merge write data into a 16-bit register under the two low byte lanes
    function automatic logic [15:0] laneMerge(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        laneMerge = res;
    endfunction

    // Register decode shared by the write, clear and mask paths
    function automatic logic regHit(
        input logic       strobe,
        input logic [7:0] idx,
        input logic [7:0] target
    );
        regHit = strobe && (idx == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0]            cfg_q;
    logic [15:0]            cfg_d;
    logic [`GPF_IRQ_W-1:0]  irqStat_q;
    logic [`GPF_IRQ_W-1:0]  irqStat_d;
    logic [`GPF_IRQ_W-1:0]  irqMask_q;
    logic [`GPF_IRQ_W-1:0]  irqMask_d;
    logic [`GPF_IRQ_W-1:0]  events;
    logic [1:0]             gpInPrev_q;
    logic                   fault_d;
    logic                   access;
    logic                   wrAccess;
    logic                   rdAccess;
    logic [7:0]             index;
    logic [31:0]            rdData;
    logic [15:0]            cfgView;
    gpf_fault_mode_t        faultMode;
    logic                   faultDrive;
    logic                   faultLevel;
    logic [1:0]             gpInEn;
    logic [1:0]             gpOutEn;
    logic [1:0]             gpLevel;
    logic                   anyError;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    assign faultMode = gpf_fault_mode_t'(cfg_q[`GPF_FAULT_MODE_HI:`GPF_FAULT_MODE_LO]);
    assign gpInEn    = {cfg_q[`GPF_P1_IN_EN], cfg_q[`GPF_P0_IN_EN]};
    assign gpOutEn   = {cfg_q[`GPF_P1_OUT_EN], cfg_q[`GPF_P0_OUT_EN]};
    assign gpLevel   = {cfg_q[`GPF_P1_LEVEL], cfg_q[`GPF_P0_LEVEL]};
    assign anyError  = |errSources;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack for one cycle

    // A raised ack blocks a second take of the same request
    assign access   = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
    assign wrAccess = access & wbReq.we;
    assign rdAccess = access & ~wbReq.we;
    assign index    = wordIndex(wbReq.adr);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wbRsp.ack <= 1'b0;
        end else if (ce) begin
            wbRsp.ack <= access;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wbRsp.dat <= 32'h0000_0000;
        end else if (ce) begin
            if (rdAccess) begin
                wbRsp.dat <= rdData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register

    // Reserved and unimplemented bits are masked on every write
    always_comb begin
        cfg_d = cfg_q;
        if (regHit(wrAccess, index, `GPF_IDX_CONFIG)) begin
            cfg_d = laneMerge(cfg_q, wbReq.dat, wbReq.sel) & `GPF_CONFIG_WMASK;
        end
    end

    // Data bits keep their written value whatever the enables say
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `GPF_CONFIG_RST;
        end else if (ce) begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read view of the configuration register

    always_comb begin
        cfgView = cfg_q;
        if (faultMode == FM_ERRIN) begin
            cfgView[`GPF_FAULT_LEVEL] = faultPinIn;
        end
        if (gpInEn[0]) begin
            cfgView[`GPF_P0_LEVEL] = gpIn[0];
        end
        if (gpInEn[1]) begin
            cfgView[`GPF_P1_LEVEL] = gpIn[1];
        end
        cfgView[`GPF_RSVD_HI:`GPF_RSVD_LO] = 2'b00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux; unmapped indices read as zero

    always_comb begin
        rdData = 32'h0000_0000;
        case (index)
            `GPF_IDX_CONFIG: begin
                rdData[15:0] = cfgView;
            end
            `GPF_IDX_IDENT: begin
                rdData[15:0] = ID_CODE;
            end
            `GPF_IDX_IRQ_STAT: begin
                rdData[`GPF_IRQ_W-1:0] = irqStat_q;
            end
            `GPF_IDX_IRQ_MASK: begin
                rdData[`GPF_IRQ_W-1:0] = irqMask_q;
            end
            default: begin
                rdData = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter fault flag

    always_comb begin
        fault_d = anyError;
        if (faultMode == FM_ERRIN) begin
            fault_d = anyError | ~faultPinIn;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            adcFault <= 1'b0;
        end else if (ce) begin
            adcFault <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault pin function
    // Open drain only ever pulls low; the line is pulled up outside

    always_comb begin
        faultDrive = 1'b0;
        faultLevel = 1'b1;
        case (faultMode)
            FM_OFF: begin
                faultDrive = 1'b0;
                faultLevel = 1'b1;
            end
            FM_ERRIN: begin
                faultDrive = 1'b0;
                faultLevel = 1'b1;
            end
            FM_ODERR: begin
                faultDrive = anyError;
                faultLevel = 1'b0;
            end
            FM_GPO: begin
                faultDrive = 1'b1;
                faultLevel = cfg_q[`GPF_FAULT_LEVEL];
            end
            default: begin
                faultDrive = 1'b0;
                faultLevel = 1'b1;
            end
        endcase
    end

    gpf_pin_cell u_fault_pin (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .drive (faultDrive),
        .level (faultLevel),
        .pin   (faultPin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // General pins: driven only while their output enable is set
    // Both enables set: the output wins and a read returns the pin

    gpf_pin_cell u_gp0_pin (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .drive (gpOutEn[0]),
        .level (gpLevel[0]),
        .pin   (gpPin[0])
    );

    gpf_pin_cell u_gp1_pin (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .drive (gpOutEn[1]),
        .level (gpLevel[1]),
        .pin   (gpPin[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gpInPrev_q <= 2'b00;
        end else if (ce) begin
            gpInPrev_q <= gpIn;
        end
    end

    // Rising fault flag and a change on an enabled general input
    // Edges count only while the input enable is set, so a pin with its input enable clear raises nothing
    always_comb begin
        events = '0;
        events[`GPF_IRQ_FAULT] = fault_d & ~adcFault;
        events[`GPF_IRQ_PIN0]  = gpInEn[0] & (gpIn[0] ^ gpInPrev_q[0]);
        events[`GPF_IRQ_PIN1]  = gpInEn[1] & (gpIn[1] ^ gpInPrev_q[1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by a read; a new event wins over the clear

    // Clear acts at the taking edge; events of that same cycle stay set
    always_comb begin
        irqStat_d = irqStat_q;
        if (regHit(rdAccess, index, `GPF_IDX_IRQ_STAT)) begin
            irqStat_d = '0;
        end
        irqStat_d = irqStat_d | events;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_q <= '0;
        end else if (ce) begin
            irqStat_q <= irqStat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt mask

    always_comb begin
        irqMask_d = irqMask_q;
        if (regHit(wrAccess, index, `GPF_IDX_IRQ_MASK) && wbReq.sel[0]) begin
            irqMask_d = wbReq.dat[`GPF_IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask_q <= `GPF_IRQ_MASK_RST;
        end else if (ce) begin
            irqMask_q <= irqMask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output, aligned with the status register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irqStat_d & irqMask_d);
        end
    end

endmodule

// ==== test/gpf_pin_control_monitor.sv ====
// Port assertions for the pin control block
`timescale 1ns/100ps
module gpf_pin_control_monitor #(
    parameter int          ERR_W   = 4,
    parameter logic [15:0] ID_CODE = 16'h0000
) (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        ce,
    input wire gpf_pkg::gpf_wb_req_t        wbReq,
    input wire gpf_pkg::gpf_wb_rsp_t        wbRsp,
    input wire logic [ERR_W-1:0]            errSources,
    input wire logic                        adcFault,
    input wire logic                        faultPinIn,
    input wire gpf_pkg::gpf_pin_drv_t       faultPin,
    input wire logic [1:0]                  gpIn,
    input wire gpf_pkg::gpf_pin_drv_t [1:0] gpPin,
    input wire logic                        irq
);
    import gpf_pkg::*;
    logic [10:0] cfg_q;
    logic        take;
    logic        faultExp;
    assign take = ce && wbReq.cyc && wbReq.stb && !wbRsp.ack;
    assign faultExp = (|errSources) || (cfg_q[10:9] == 2'b01 && !faultPinIn);
    // Shadow of the writable config bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else if (take && wbReq.we && wbReq.adr[9:2] == 8'h06) begin
            cfg_q <= {wbReq.sel[1] ? wbReq.dat[10:8] : cfg_q[10:8],
                      wbReq.sel[0] ? wbReq.dat[7:0] & 8'h3f : cfg_q[7:0]};
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence cfgRd;
        take && !wbReq.we && wbReq.adr[9:2] == 8'h06;
    endsequence
    sequence idRd;
        take && !wbReq.we && wbReq.adr[9:2] == 8'h07;
    endsequence
    ack_pulse_a: assert property (wbRsp.ack && ce |=> !wbRsp.ack) else $error("ack held too long");
    ack_delay_a: assert property (take |=> wbRsp.ack) else $error("ack late");
    fault_off_a: assert property (ce && cfg_q[10:9] == 2'b00 |=> faultPin.oeN)
        else $error("fault pin driven while off");
    fault_in_a: assert property (ce |=> adcFault == $past(faultExp))
        else $error("fault flag wrong");
    fault_od_a: assert property (ce && cfg_q[10:9] == 2'b10 |=>
        faultPin.oeN == !(|$past(errSources)) && !faultPin.out) else $error("open drain wrong");
    fault_gpo_a: assert property (ce && cfg_q[10:9] == 2'b11 |=>
        !faultPin.oeN && faultPin.out == $past(cfg_q[8])) else $error("fault output wrong");
    gp_drive_a: assert property (ce |=> {gpPin[1].oeN, gpPin[0].oeN} == ~$past(cfg_q[3:2])
        && {gpPin[1].out, gpPin[0].out} == $past(cfg_q[1:0])) else $error("general pin wrong");
    rsvd_zero_a: assert property (cfgRd |=> wbRsp.ack && wbRsp.dat[31:11] == '0 && wbRsp.dat[7:6] == 2'b00)
        else $error("reserved bits set");
    ident_read_a: assert property (idRd |=> wbRsp.dat == {16'h0000, ID_CODE})
        else $error("identity wrong");
endmodule
bind gpf_pin_control gpf_pin_control_monitor #(.ERR_W(ERR_W), .ID_CODE(ID_CODE)) mon (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp), .errSources(errSources),
    .adcFault(adcFault), .faultPinIn(faultPinIn), .faultPin(faultPin), .gpIn(gpIn), .gpPin(gpPin), .irq(irq));

// ==== test/gpf_pin_partner.sv ====
// Outside circuit on the general pins and the shared fault line
`timescale 1ns/100ps
module gpf_pin_partner (
    input wire gpf_pkg::gpf_pin_drv_t [1:0] gpPin,
    input wire gpf_pkg::gpf_pin_drv_t       faultPin,
    input wire logic [1:0]                  extLevel,
    input wire logic                        extPullLow,
    output logic [1:0]                      gpIn,
    output logic                            faultPinIn
);
    import gpf_pkg::*;
    // Outside drives a general pin only while the block releases it
    assign gpIn[0] = gpPin[0].oeN ? extLevel[0] : gpPin[0].out;
    assign gpIn[1] = gpPin[1].oeN ? extLevel[1] : gpPin[1].out;
    // Pulled-up line, wired low by the block or another device
    assign faultPinIn = (faultPin.oeN | faultPin.out) & !extPullLow;
endmodule

// ==== test/gpf_pin_control_test.sv ====
// Self-checking bench for the pin control block
`timescale 1ns/100ps
module gpf_pin_control_test;
    import gpf_pkg::*;
    localparam logic [15:0] ID = 16'h3c5a; // Arbitrary identity value
    logic               mclk = 0, rst_n = 0, ce = 1, extPullLow = 0, adcFault, faultPinIn, irq;
    logic [3:0]         errSources = '0;
    logic [1:0]         extLevel = '0, gpIn;
    logic [15:0]        rd;
    gpf_wb_req_t        wbReq = '0;
    gpf_wb_rsp_t        wbRsp;
    gpf_pin_drv_t       faultPin;
    gpf_pin_drv_t [1:0] gpPin;
    int                 errTotal = 0, testsRun = 0;
    always #2.5 mclk = ~mclk;
    gpf_pin_control #(.ERR_W(4), .ID_CODE(ID)) DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wbReq(wbReq),
        .wbRsp(wbRsp), .errSources(errSources), .adcFault(adcFault), .faultPinIn(faultPinIn),
        .faultPin(faultPin), .gpIn(gpIn), .gpPin(gpPin), .irq(irq));
    gpf_pin_partner far (.gpPin(gpPin), .faultPin(faultPin), .extLevel(extLevel),
        .extPullLow(extPullLow), .gpIn(gpIn), .faultPinIn(faultPinIn));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            errTotal++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: {2'h0, idx, 2'h0}, dat: {16'h0000, d}};
        do begin
            @(posedge mclk);
            n++;
        end while (wbRsp.ack !== 1'b1);
        r = wbRsp.dat[15:0];
        wbReq <= '0;
        chk(n, 2);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic finishTest;
        $display("checks %0d bad %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic testReset;
        wb(0, 8'h06, 0, rd);
        chk(rd, 0);
        chk({faultPin.oeN, gpPin[1].oeN, gpPin[0].oeN}, 3'b111);
        wb(1, 8'h07, 16'hffff, rd);
        wb(0, 8'h07, 0, rd);
        chk(rd, ID);
        wb(1, 8'h3f, 16'h0101, rd);
        wb(0, 8'h3f, 0, rd);
        chk(rd, 0);
        $display("reset test done");
    endtask
    task automatic testPins;
        wb(1, 8'h06, 16'h000d, rd);
        settle(1);
        chk({gpPin[1].oeN, gpPin[0].oeN, gpPin[1].out, gpPin[0].out}, 4'b0001);
        wb(1, 8'h06, 16'h0003, rd);
        settle(1);
        chk({gpPin[1].oeN, gpPin[0].oeN}, 2'b11);
        wb(0, 8'h06, 0, rd);
        chk(rd, 16'h0003);
        extLevel <= 2'b10;
        wb(1, 8'h06, 16'h0031, rd);
        wb(0, 8'h06, 0, rd);
        chk(rd, 16'h0032);
        $display("pin test done");
    endtask
    task automatic testFault;
        wb(1, 8'h06, 16'h0300, rd);
        extPullLow <= 1'b1;
        settle(2);
        chk(adcFault, 1);
        wb(0, 8'h06, 0, rd);
        chk(rd, 16'h0200);
        wb(1, 8'h06, 16'h0400, rd);
        extPullLow <= 1'b0;
        errSources <= 4'h4;
        settle(2);
        chk({faultPin.oeN, faultPin.out, faultPinIn}, 3'b000);
        wb(1, 8'h06, 16'h0700, rd);
        errSources <= 4'h0;
        settle(1);
        chk({faultPin.oeN, faultPin.out, faultPinIn}, 3'b011);
        wb(1, 8'h06, 16'h0000, rd);
        settle(1);
        chk(faultPin.oeN, 1);
        $display("fault test done");
    endtask
    task automatic testIrq;
        wb(0, 8'h20, 0, rd);
        errSources <= 4'h1;
        settle(3);
        chk(irq, 0);
        wb(1, 8'h21, 16'h0001, rd);
        settle(2);
        chk(irq, 1);
        wb(0, 8'h20, 0, rd);
        chk(rd[0], 1);
        settle(2);
        chk(irq, 0);
        wb(0, 8'h21, 0, rd);
        chk(rd, 16'h0001);
        ce <= 1'b0;
        errSources <= 4'h0;
        settle(3);
        chk(adcFault, 1);
        @(posedge mclk);
        ce <= 1'b1;
        settle(2);
        chk(adcFault, 0);
        wb(1, 8'h06, 16'h0010, rd);
        wb(1, 8'h21, 16'h0002, rd);
        wb(0, 8'h20, 0, rd);
        chk(rd, 16'h0000);
        extLevel <= 2'b11;
        settle(2);
        chk(irq, 1);
        wb(0, 8'h20, 0, rd);
        chk(rd, 16'h0002);
        $display("irq test done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        testReset;
        testPins;
        testFault;
        testIrq;
        finishTest;
    end
    initial begin
        #20000;
        errTotal++;
        finishTest;
    end
endmodule
